// [pkg/prictl_pkg.sv]
// Package of constants for the endpoint reset isolation controller.
`default_nettype none

package prictl_pkg;

    // ****************************************************************
    // Control port write sequence
    // ****************************************************************

    // Offset, values and strobe written to the isolator's control port, and its OKAY response.
    localparam logic [11:0] BLOCK_REG_ADDR   = 12'h008;
    localparam logic [31:0] BLOCK_ON_DATA    = 32'h0000_0001;
    localparam logic [31:0] BLOCK_OFF_DATA   = 32'h0000_0000;
    localparam logic [3:0]  FULL_STRB        = 4'hf;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;

    // ****************************************************************
    // Clock and synchroniser
    // ****************************************************************

    localparam int          CLK_PERIOD_NS    = 20;
    localparam int          SYNC_STAGES      = 2;

    // Controller states.
    typedef enum logic [2:0] {
        PRICTL_PASS      = 3'h0,
        PRICTL_BLK_WRITE = 3'h1,
        PRICTL_BLK_RESP  = 3'h2,
        PRICTL_BLOCKED   = 3'h3,
        PRICTL_UNB_WRITE = 3'h4,
        PRICTL_UNB_RESP  = 3'h5
    } prictl_state_t;

endpackage

`default_nettype wire

// [logic/prictl_sync.sv]
// Level synchroniser of STAGES flops (at least two) with an asynchronous reset value.
`default_nettype none

module prictl_sync #(
    parameter int   STAGES    = 2,
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset.
    input  wire logic i_mclk,
    input  wire logic i_arst_n,
    // Level in and synchronised level out.
    input  wire logic i_level,
    output logic      o_level
);

    logic [STAGES-1:0] chain;

    // Refuse chains too short to resolve metastability.
    if (STAGES < 2) begin : g_bad_stages
        $error("prictl_sync needs at least two stages");
    end

    // Only the last stage is read outside this chain.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            chain <= {STAGES{RESET_VAL}};
        end else begin
            chain <= {chain[STAGES-2:0], i_level};
        end
    end

    assign o_level = chain[STAGES-1];

endmodule // prictl_sync

`default_nettype wire

// [logic/prictl_top.sv]
// Endpoint reset isolation controller driving an AXI-Lite isolator.
// ********************************************************************
// Notes on behaviour
// - Endpoint reset falling starts control-port writes that block the isolator.
// - Blocking is done by an AXI-Lite write, never by a level.
// - Endpoint reset rising starts control-port writes that unblock the isolator.
// - Unblocking is likewise done by an AXI-Lite write.
// - While blocked, downstream reset follows the upstream reset input.
// - Downstream reset is the reset of the user logic behind isolator.
// - Upstream reset is normally tied low, holding user logic in reset.
// - User logic may be reset only after the isolator is blocking; a controller reset on i_arst_n drives downstream reset low at once.
// - User logic reset derives from the endpoint's reset output.
// - Endpoint user clock stops in fundamental reset; it is not used.
// - Controller runs on a free-running fabric clock.
// ********************************************************************
`default_nettype none

module prictl_top (
    // Free-running fabric clock and reset.
    input  wire logic        i_mclk,
    input  wire logic        i_arst_n,
    // Endpoint reset and upstream reset.
    input  wire logic        i_endpoint_axi_reset_n,
    input  wire logic        i_up_reset_n,
    // Downstream reset and state.
    output logic             o_down_reset_n,
    output logic             o_blocked,
    output logic             o_resp_error,
    // AXI-Lite write address channel.
    output logic             o_awvalid,
    input  wire logic        i_awready,
    output logic [11:0]      o_awaddr,
    output logic [2:0]       o_awprot,
    // AXI-Lite write data channel.
    output logic             o_wvalid,
    input  wire logic        i_wready,
    output logic [31:0]      o_wdata,
    output logic [3:0]       o_wstrb,
    // AXI-Lite write response channel.
    input  wire logic        i_bvalid,
    output logic             o_bready,
    input  wire logic [1:0]  i_bresp,
    // AXI-Lite read channels, unused and held idle.
    output logic             o_arvalid,
    output logic [11:0]      o_araddr,
    output logic [2:0]       o_arprot,
    output logic             o_rready
);

    // Every check below runs on the fabric clock and rests during reset.
    default clocking chk_cb @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);

    // ****************************************************************
    // Endpoint reset capture
    // ****************************************************************

    logic                   ep_rst_n;
    logic                   ep_rst_d;
    prictl_pkg::prictl_state_t state;

    // The endpoint reset comes from another domain, so it is synchronised
    // and only the synchronised copy is edge-detected.
    prictl_sync #(
        .STAGES    (prictl_pkg::SYNC_STAGES),
        .RESET_VAL (1'b0)
    ) u_ep_sync (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_level  (i_endpoint_axi_reset_n),
        .o_level  (ep_rst_n)
    );

    // Delayed copy for edge detection.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ep_rst_d <= 1'b0;
        end else begin
            ep_rst_d <= ep_rst_n;
        end
    end

    wire ep_fall = ep_rst_d & ~ep_rst_n;
    wire ep_rise = ~ep_rst_d & ep_rst_n;

    // ****************************************************************
    // Sequence state machine
    // ****************************************************************

    // Starts blocked after reset: the endpoint reset is taken as asserted
    // until seen high, so user logic never runs beside an unknown isolator.
    // The first unblock is therefore a write issued on the first rise.
    wire aw_done = o_awvalid & i_awready;
    wire w_done  = o_wvalid & i_wready;
    wire b_done  = o_bready & i_bvalid;
    wire aw_left = o_awvalid & ~i_awready;
    wire w_left  = o_wvalid & ~i_wready;

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= prictl_pkg::PRICTL_BLOCKED;
        end else begin
            case (state)
                prictl_pkg::PRICTL_PASS: begin
                    // Level, not edge: a fall that lands during the unblock
                    // sequence must still end in a block.
                    if (!ep_rst_n) begin
                        state <= prictl_pkg::PRICTL_BLK_WRITE;
                    end
                end
                prictl_pkg::PRICTL_BLK_WRITE: begin
                    if (!aw_left && !w_left && (aw_done || w_done ||
                        (!o_awvalid && !o_wvalid))) begin
                        state <= prictl_pkg::PRICTL_BLK_RESP;
                    end
                end
                prictl_pkg::PRICTL_BLK_RESP: begin
                    if (b_done) begin
                        state <= prictl_pkg::PRICTL_BLOCKED;
                    end
                end
                prictl_pkg::PRICTL_BLOCKED: begin
                    if (ep_rise || (ep_rst_n && ep_rst_d)) begin
                        state <= prictl_pkg::PRICTL_UNB_WRITE;
                    end
                end
                prictl_pkg::PRICTL_UNB_WRITE: begin
                    if (!aw_left && !w_left && (aw_done || w_done ||
                        (!o_awvalid && !o_wvalid))) begin
                        state <= prictl_pkg::PRICTL_UNB_RESP;
                    end
                end
                prictl_pkg::PRICTL_UNB_RESP: begin
                    if (b_done) begin
                        state <= prictl_pkg::PRICTL_PASS;
                    end
                end
                default: begin
                    state <= prictl_pkg::PRICTL_BLOCKED;
                end
            endcase
        end
    end

    // ****************************************************************
    // AXI-Lite write channels
    // ****************************************************************

    wire start_blk = (state == prictl_pkg::PRICTL_PASS) & ~ep_rst_n;
    wire start_unb = (state == prictl_pkg::PRICTL_BLOCKED) & ep_rst_n;

    // Address and data are raised together and each drops on its own
    // handshake, so the slave may take them in either order.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_awvalid <= 1'b0;
            o_wvalid  <= 1'b0;
            o_wdata   <= prictl_pkg::BLOCK_ON_DATA;
        end else if (start_blk || start_unb) begin
            o_awvalid <= 1'b1;
            o_wvalid  <= 1'b1;
            o_wdata   <= start_blk ? prictl_pkg::BLOCK_ON_DATA
                                   : prictl_pkg::BLOCK_OFF_DATA;
        end else begin
            if (aw_done) begin
                o_awvalid <= 1'b0;
            end
            if (w_done) begin
                o_wvalid <= 1'b0;
            end
        end
    end

    // Response is accepted in the state that waits for it.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_bready <= 1'b0;
        end else begin
            o_bready <= ((state == prictl_pkg::PRICTL_BLK_RESP) ||
                         (state == prictl_pkg::PRICTL_UNB_RESP)) & ~b_done;
        end
    end

    // A non-OKAY answer is kept for inspection; the sequence still moves on
    // because retrying forever would hold the user logic hostage.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_resp_error <= 1'b0;
        end else if (b_done) begin
            o_resp_error <= (i_bresp != prictl_pkg::RESP_OKAY);
        end
    end

    // Constant channel fields, still from flops.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_awaddr  <= prictl_pkg::BLOCK_REG_ADDR;
            o_awprot  <= 3'h0;
            o_wstrb   <= prictl_pkg::FULL_STRB;
            o_arvalid <= 1'b0;
            o_araddr  <= 12'h000;
            o_arprot  <= 3'h0;
            o_rready  <= 1'b0;
        end else begin
            o_awaddr  <= prictl_pkg::BLOCK_REG_ADDR;
            o_awprot  <= 3'h0;
            o_wstrb   <= prictl_pkg::FULL_STRB;
            o_arvalid <= 1'b0;
            o_araddr  <= 12'h000;
            o_arprot  <= 3'h0;
            o_rready  <= 1'b0;
        end
    end

    // ****************************************************************
    // Downstream reset
    // ****************************************************************

    // Registered on the next state so it matches the state each cycle.
    // Pass-through applies only once the block write has been answered.
    logic blocked_next;
    assign blocked_next = (state == prictl_pkg::PRICTL_BLOCKED) ||
        (state == prictl_pkg::PRICTL_BLK_RESP && b_done) ||
        (state == prictl_pkg::PRICTL_UNB_WRITE) ||
        (state == prictl_pkg::PRICTL_UNB_RESP && !b_done);

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_blocked      <= 1'b1;
            o_down_reset_n <= 1'b0;
        end else begin
            o_blocked      <= blocked_next;
            o_down_reset_n <= blocked_next ? i_up_reset_n : 1'b1;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************

    pass_follows_a: assert property (o_blocked |-> ##1
        (!o_blocked || o_down_reset_n == $past(i_up_reset_n)))
        else $error("downstream reset not following upstream");
    unblock_high_a: assert property (!o_blocked |-> o_down_reset_n)
        else $error("downstream reset low while unblocked");
    fall_writes_a: assert property (start_blk |=> o_awvalid &&
        o_wvalid && o_wdata == prictl_pkg::BLOCK_ON_DATA)
        else $error("no block write after endpoint reset fall");
    rise_writes_a: assert property (start_unb |=> o_awvalid &&
        o_wvalid && o_wdata == prictl_pkg::BLOCK_OFF_DATA)
        else $error("no unblock write after endpoint reset rise");
    block_by_write_a: assert property (
        $rose(o_blocked) |-> $past(b_done))
        else $error("blocked without a write response");
    unblock_by_write_a: assert property (
        $fell(o_blocked) |-> $past(b_done))
        else $error("unblocked without a write response");
    reset_after_block_a: assert property (
        $fell(o_down_reset_n) |-> o_blocked)
        else $error("user logic reset while isolator open");
    sync_delay_a: assert property (ep_fall |->
        $past(i_endpoint_axi_reset_n, 3) && !$past(i_endpoint_axi_reset_n, 2))
        else $error("endpoint reset edge not synchronised");
    resp_wait_a: assert property (
        (state == prictl_pkg::PRICTL_BLK_RESP && !b_done) |=> !o_blocked)
        else $error("block completed without response");

    block_seq_c: cover property (start_blk ##[1:40] $rose(o_blocked));
    unblock_seq_c: cover property (start_unb ##[1:40] $fell(o_blocked));
    resp_err_c: cover property ($rose(o_resp_error));
    follow_c: cover property (o_blocked && $rose(o_down_reset_n));

endmodule // prictl_top

`default_nettype wire

// [testbench/prictl_iso_model.sv]
// Behavioural model of the isolator control port behind the controller.
`default_nettype none

module prictl_iso_model (
    // Clock and reset.
    input  wire logic        i_mclk,
    input  wire logic        i_arst_n,
    // Write channels from the controller.
    input  wire logic        i_awvalid,
    input  wire logic [11:0] i_awaddr,
    input  wire logic        i_wvalid,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_bready,
    // Answer delay and error injection.
    input  wire logic [3:0]  i_delay,
    input  wire logic        i_err,
    // Answers and the state seen by the bench.
    output logic             o_awready,
    output logic             o_wready,
    output logic             o_bvalid,
    output logic [1:0]       o_bresp,
    output logic             o_blocking,
    output logic [31:0]      o_data,
    output logic [7:0]       o_writes
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Control port
    // ****************************************************************

    logic       pend;
    logic [3:0] cnt;

    // Both channels are taken together, so one ready serves both.
    assign o_wready = o_awready;

    // One write at a time; ready and response each wait i_delay cycles.
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_awready  <= 1'b0;
            o_bvalid   <= 1'b0;
            o_bresp    <= 2'h3;
            o_blocking <= 1'b0;
            o_data     <= 32'h0;
            o_writes   <= 8'h0;
            pend       <= 1'b0;
            cnt        <= 4'h0;
        end else begin
            o_awready <= 1'b0;
            // Idle response lines alternate between 2'h3 and OKAY, or 2'h1 and 2'h2 after an error answer, so stale values never hold still.
            if (!o_bvalid) begin
                o_bresp <= ~o_bresp;
            end
            if (i_awvalid && i_wvalid && !o_awready && !pend && !o_bvalid) begin
                cnt <= cnt + 4'h1;
                if (cnt == i_delay) begin
                    o_awready <= 1'b1;
                    cnt       <= 4'h0;
                end
            end
            if (o_awready) begin
                pend     <= 1'b1;
                o_data   <= i_wdata;
                o_writes <= o_writes + 8'h01;
                if (i_awaddr == prictl_pkg::BLOCK_REG_ADDR) begin
                    o_blocking <= (i_wdata == prictl_pkg::BLOCK_ON_DATA);
                end
            end
            if (pend) begin
                cnt <= cnt + 4'h1;
                if (cnt == i_delay) begin
                    o_bvalid <= 1'b1;
                    o_bresp  <= i_err ? 2'h2 : prictl_pkg::RESP_OKAY;
                    pend     <= 1'b0;
                    cnt      <= 4'h0;
                end
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

endmodule // prictl_iso_model

`default_nettype wire

// [testbench/test_prictl_top.sv]
// Self-checking bench for the endpoint reset isolation controller.
`default_nettype none

module test_prictl_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals and instances
    // ****************************************************************

    logic mclk, arst_n, ep_n, up_n, err, down_n, blocked, resp_err;
    logic awvalid, awready, wvalid, wready, bvalid, bready, blocking;
    logic arvalid, rready;
    logic [3:0]  delay, wstrb;
    logic [11:0] awaddr, araddr;
    logic [2:0]  awprot, arprot;
    logic [31:0] wdata, mdata;
    logic [1:0]  bresp;
    logic [7:0]  writes;
    int          n_fail;
    int          checks;

    // The clock is free running, as the controller needs in reset.
    always #(prictl_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;

    prictl_top prictl_top_i (
        .i_mclk(mclk), .i_arst_n(arst_n), .i_endpoint_axi_reset_n(ep_n),
        .i_up_reset_n(up_n), .o_down_reset_n(down_n), .o_blocked(blocked),
        .o_resp_error(resp_err), .o_awvalid(awvalid), .i_awready(awready),
        .o_awaddr(awaddr), .o_awprot(awprot), .o_wvalid(wvalid),
        .i_wready(wready), .o_wdata(wdata), .o_wstrb(wstrb),
        .i_bvalid(bvalid), .o_bready(bready), .i_bresp(bresp),
        .o_arvalid(arvalid), .o_araddr(araddr), .o_arprot(arprot),
        .o_rready(rready)
    );

    prictl_iso_model prictl_iso_model_i (
        .i_mclk(mclk), .i_arst_n(arst_n), .i_awvalid(awvalid),
        .i_awaddr(awaddr), .i_wvalid(wvalid), .i_wdata(wdata),
        .i_bready(bready), .i_delay(delay), .i_err(err),
        .o_awready(awready), .o_wready(wready), .o_bvalid(bvalid),
        .o_bresp(bresp), .o_blocking(blocking), .o_data(mdata),
        .o_writes(writes)
    );

    // ****************************************************************
    // Compare, wait and closing tasks
    // ****************************************************************

    task automatic check_bit(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic check_word(input string n, input logic [31:0] e,
                              input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic stop_test;
        $display("Counts: %0d checks, %0d failures", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Waits for o_blocked; also watches every write and the reset order.
    task automatic wait_blocked(input logic exp);
        logic last_down;
        last_down = down_n;
        for (int i = 0; i < 80 && blocked !== exp; i++) begin
            @(negedge mclk);
            // The isolator may leave blocking before the unblock answer,
            // so only a falling downstream reset is held against it.
            if (last_down === 1'b1 && down_n === 1'b0) begin
                check_bit("isolator blocks first", 1'b1, blocking);
            end
            last_down = down_n;
            if (awvalid === 1'b1) begin
                check_word("address", 32'(prictl_pkg::BLOCK_REG_ADDR),
                           32'(awaddr));
                check_word("strobe", 32'(prictl_pkg::FULL_STRB), 32'(wstrb));
            end
        end
        if (blocked !== exp) begin
            n_fail++;
            $display("ERROR o_blocked wait ran out");
            stop_test();
        end
    endtask

    // Starts a command by moving the endpoint reset, then checks the end.
    task automatic run_cmd(input logic ep, input logic [7:0] nwr);
        @(posedge mclk);
        ep_n <= ep;
        wait_blocked(~ep);
        @(negedge mclk);
        check_word("data", ep ? prictl_pkg::BLOCK_OFF_DATA
                              : prictl_pkg::BLOCK_ON_DATA, mdata);
        check_bit("isolator state", ~ep, blocking);
        check_word("writes", 32'(nwr), 32'(writes));
        check_bit("down reset", ep | up_n, down_n);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************

    task automatic test_reset_and_unblock;
        @(negedge mclk);
        check_bit("blocked in reset", 1'b1, blocked);
        check_bit("down in reset", 1'b0, down_n);
        check_bit("read idle", 1'b0, arvalid | rready | awvalid);
        check_word("idle fields", 32'h0, 32'({awprot, araddr, arprot}));
        @(posedge mclk);
        arst_n <= 1'b1;
        wait_blocked(1'b0);
        check_bit("unblocked down", 1'b1, down_n);
    endtask

    // Upstream reset passes through while blocked, both high and low.
    task automatic test_follow;
        run_cmd(1'b0, 8'd2);
        @(posedge mclk);
        up_n <= 1'b1;
        repeat (3) @(negedge mclk);
        check_bit("follow high", 1'b1, down_n);
        @(posedge mclk);
        up_n <= 1'b0;
        repeat (3) @(negedge mclk);
        check_bit("follow low", 1'b0, down_n);
        check_word("no extra write", 32'd2, 32'(writes));
    endtask

    // A slow partner and an error answer; the state still advances.
    task automatic test_slow_error;
        @(posedge mclk);
        delay <= 4'h3;
        err   <= 1'b1;
        run_cmd(1'b1, 8'd3);
        check_bit("error flag", 1'b1, resp_err);
        @(posedge mclk);
        err <= 1'b0;
        run_cmd(1'b0, 8'd4);
        check_bit("error clear", 1'b0, resp_err);
    endtask

    // Reset in mid-run returns to blocked, then unblocks once more.
    task automatic test_mid_reset;
        @(posedge mclk);
        delay <= 4'h0;
        run_cmd(1'b1, 8'd5);
        @(posedge mclk);
        arst_n <= 1'b0;
        @(negedge mclk);
        check_bit("blocked again", 1'b1, blocked);
        check_bit("down again", 1'b0, down_n);
        @(posedge mclk);
        arst_n <= 1'b1;
        wait_blocked(1'b0);
        check_word("writes after reset", 32'd1, 32'(writes));
    endtask

    initial begin
        mclk   = 1'b0;
        arst_n = 1'b0;
        ep_n   = 1'b1;
        up_n   = 1'b0;
        delay  = 4'h0;
        err    = 1'b0;
        n_fail = 0;
        checks = 0;
        repeat (2) @(posedge mclk);
        test_reset_and_unblock();
        test_follow();
        test_slow_error();
        test_mid_reset();
        stop_test();
    end

endmodule // test_prictl_top

`default_nettype wire
